// ---- hdl/imu_defs.vh ----
// constants for the inertial sensor serial slave and timing block
// Function
// R1: first fresh data appears about 175 ms after power-up, and about 55 ms after a reset; the code waits 175 ms after rst_n, 55 ms after the reset command.
// R2: the host holds the reset input low for at least 10 us to start a proper recovery; the bench holds it 12 cycles (120 ns) first, 1000 cycles later.
// R3: a flash back-up command takes about 55 ms, and no new data comes until it ends.
// R4: a flash integrity test takes about 20 ms before new data comes again.
// R5: an external sync clock of 0.8 to 1.1 kHz is accepted, and slower sync still works.
// R6: each output bit is shifted onto the output line on the falling serial clock edge.
// R7: each input bit is sampled on the rising serial clock edge.
// R8: the host leaves at least 9 us idle between single-word transfers, none in a burst.
// R9: the host keeps sync high pulses at least 25 us wide and periods at least 910 us long.
// R10: data ready follows a sync pulse by about 670 us, and data is invalid for about 210 us.
// R11: four configurable digital lines exist, and the fourth can serve as the sync input; here only lines two and three are configurable.
// R12: each 16-bit transfer is framed by chip select low, and clock edges are ignored while high.
// R13: the link is mode 3, most significant bit first, 16-bit words, with the device as slave.
// R14: a register read takes two transfers, and the data returns during the second.
// R15: without setup the device samples autonomously at 819.2 samples per second.
// R16: the first digital line pulses high at the end of every sample cycle.
`ifndef IMU_DEFS_VH
`define IMU_DEFS_VH
// ****************************************
// clock and times
// ****************************************
`define IMU_CLK_MHZ 100
`define IMU_STARTUP_MS 175
`define IMU_RESET_REC_MS 55
`define IMU_FLASH_BKUP_MS 55
`define IMU_FLASH_TEST_MS 20
// ms to us is times 1000, us to cycles is times the clock in MHz; all fit 32 bits
`define IMU_STARTUP_CYC (`IMU_STARTUP_MS * 1000 * `IMU_CLK_MHZ)
`define IMU_RESET_REC_CYC (`IMU_RESET_REC_MS * 1000 * `IMU_CLK_MHZ)
`define IMU_FLASH_BKUP_CYC (`IMU_FLASH_BKUP_MS * 1000 * `IMU_CLK_MHZ)
`define IMU_FLASH_TEST_CYC (`IMU_FLASH_TEST_MS * 1000 * `IMU_CLK_MHZ)
// 819.2 sps: period 1220.703125 us, rounded down to whole cycles
`define IMU_SAMPLE_PERIOD_NS 1220703
`define IMU_SAMPLE_CYC (`IMU_SAMPLE_PERIOD_NS * `IMU_CLK_MHZ / 1000)
`define IMU_SYNC_TO_DRDY_US 670
`define IMU_SYNC_TO_DRDY_CYC (`IMU_SYNC_TO_DRDY_US * `IMU_CLK_MHZ)
`define IMU_DATA_INVALID_US 210
`define IMU_DATA_INVALID_CYC (`IMU_DATA_INVALID_US * `IMU_CLK_MHZ)
`define IMU_DRDY_PULSE_CYC 16'h0064
// ****************************************
// serial word and commands
// ****************************************
`define IMU_WORD_BITS 16
`define IMU_WR_BIT 15
`define IMU_ADDR_MSB 14
`define IMU_ADDR_LSB 8
`define IMU_CMD_ADDR 7'h3e
`define IMU_CMD_FLASH_TEST 8'h02
`define IMU_CMD_FLASH_BKUP 8'h08
`define IMU_CMD_SW_RESET 8'h80
`define IMU_DIO_CTRL_ADDR 7'h32
`define IMU_MSC_CTRL_ADDR 7'h34
`define IMU_SYNC_EN_BIT 4
`define IMU_DATA_ADDR 7'h04
`define IMU_STATUS_ADDR 7'h3c
`endif

// ---- hdl/imu_fifo.v ----
// small flip-flop fifo for sample words
`timescale 1ns/1ns
module imu_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // honest flags from the occupancy count
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointers wrap freely, depth is a power of two
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ---- hdl/imu_spi_slave.v ----
// serial slave port, sample timing and sync handling of the inertial sensor
`timescale 1ns/1ns
`include "imu_defs.vh"
module imu_spi_slave #(
  parameter STARTUP_CYC = `IMU_STARTUP_CYC,
  parameter RESET_REC_CYC = `IMU_RESET_REC_CYC,
  parameter FLASH_BKUP_CYC = `IMU_FLASH_BKUP_CYC,
  parameter FLASH_TEST_CYC = `IMU_FLASH_TEST_CYC,
  parameter SAMPLE_CYC = `IMU_SAMPLE_CYC,
  parameter SYNC_TO_DRDY_CYC = `IMU_SYNC_TO_DRDY_CYC,
  parameter DATA_INVALID_CYC = `IMU_DATA_INVALID_CYC,
  parameter FIFO_DEPTH = 16
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // serial link from host
  input wire sclk,
  input wire cs_n,
  input wire mosi,
  output reg miso,
  // sample stream from the sensor core
  input wire smp_valid,
  output wire smp_ready,
  input wire [15:0] smp_data,
  // digital lines, only lines two and three configurable
  input wire [3:0] aux_io_in,
  output wire [3:0] aux_io_out,
  output wire [3:0] aux_io_oe,
  // status
  output reg data_valid
);
  localparam ST_BOOT = 2'b00;
  localparam ST_RUN = 2'b01;
  localparam ST_BUSY = 2'b10;
  localparam [31:0] ONE = 32'h0000_0001;

  // ****************************************
  // input synchronisers
  // ****************************************
  reg [2:0] sclk_s;
  reg [1:0] cs_s;
  reg [1:0] mosi_s;
  reg [2:0] sync_s;
  wire sclk_rise = sclk_s[1] && !sclk_s[2];
  wire sclk_fall = !sclk_s[1] && sclk_s[2];
  wire cs_act = !cs_s[1];

  // two flops each; the third stage of clock and sync only feeds edge finding
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sclk_s <= 3'h7;
      cs_s <= 2'h3;
      mosi_s <= 2'h0;
      sync_s <= 3'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk};
      cs_s <= {cs_s[0], cs_n};
      mosi_s <= {mosi_s[0], mosi};
      sync_s <= {sync_s[1:0], aux_io_in[3]};
    end
  end

  // ****************************************
  // sample fifo
  // ****************************************
  wire f_valid;
  wire [15:0] f_data;
  reg f_pop;

  imu_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .in_data(smp_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // ****************************************
  // control registers and state
  // ****************************************
  reg [1:0] state;
  reg [31:0] busy_cnt;
  reg [31:0] smp_cnt;
  reg [31:0] sync_cnt;
  reg sync_pend;
  reg sync_en;
  reg [15:0] dio_ctrl;
  reg [15:0] out_reg;
  reg [15:0] drdy_cnt;
  reg [15:0] shreg;
  reg [15:0] rx;
  reg [4:0] bitcnt;
  reg sw_reset;
  reg bkup_req;
  reg test_req;
  wire end_sample;
  wire sync_rise = sync_s[1] && !sync_s[2];

  // internal cadence, or sync-driven cadence when selected on line four
  assign end_sample = (state == ST_RUN) && (sync_en ?
    (sync_pend && sync_cnt == SYNC_TO_DRDY_CYC - ONE) :
    (smp_cnt == SAMPLE_CYC - ONE)); // [R15] [R10] [R5]

  // first line drives data ready; lines two and three by level bits 10:9 and direction bits 2:1
  assign aux_io_out = {1'b0, dio_ctrl[10:9], (drdy_cnt != 16'h0000)}; // [R16] [R11]
  assign aux_io_oe = {1'b0, dio_ctrl[2:1], 1'b1}; // [R11]

  // ****************************************
  // sample timing, busy periods
  // ****************************************
  // sync handling stays edge-based so any period longer than the sync-to-ready delay, even slower than the range, keeps running
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_BOOT;
      busy_cnt <= 32'h0000_0000;
      smp_cnt <= 32'h0000_0000;
      sync_cnt <= 32'h0000_0000;
      sync_pend <= 1'b0;
      drdy_cnt <= 16'h0000;
      out_reg <= 16'h0000;
      data_valid <= 1'b0;
      f_pop <= 1'b0;
    end else begin
      f_pop <= 1'b0;
      if (drdy_cnt != 16'h0000) begin
        drdy_cnt <= drdy_cnt - 16'h0001;
      end
      if (sync_rise) begin
        sync_pend <= 1'b1;
        sync_cnt <= 32'h0000_0000;
      end else if (sync_pend) begin
        sync_cnt <= sync_cnt + ONE;
      end
      case (state)
        ST_BOOT: begin
          // power-on start-up wait
          if (busy_cnt == STARTUP_CYC - ONE) begin
            busy_cnt <= 32'h0000_0000;
            state <= ST_RUN;
          end else begin
            busy_cnt <= busy_cnt + ONE; // [R1]
          end
        end
        ST_RUN: begin
          if (sw_reset || bkup_req || test_req) begin
            data_valid <= 1'b0;
            busy_cnt <= sw_reset ? RESET_REC_CYC - ONE : // [R1]
              (bkup_req ? FLASH_BKUP_CYC - ONE : FLASH_TEST_CYC - ONE); // [R3] [R4]
            state <= ST_BUSY;
          end else begin
            smp_cnt <= (end_sample || sync_en) ? 32'h0000_0000 : smp_cnt + ONE;
            // data goes invalid while the sync-driven cycle refreshes it
            if (sync_en && sync_pend && sync_cnt == SYNC_TO_DRDY_CYC - DATA_INVALID_CYC) begin
              data_valid <= 1'b0; // [R10]
            end
            if (end_sample) begin
              // a new sync edge in this same cycle must not be lost
              if (!sync_rise) begin
                sync_pend <= 1'b0;
              end
              drdy_cnt <= `IMU_DRDY_PULSE_CYC; // [R16]
              data_valid <= 1'b1;
              if (f_valid) begin
                out_reg <= f_data;
                f_pop <= 1'b1;
              end
            end
          end
        end
        ST_BUSY: begin
          // reset recovery, flash back-up or flash test: no new data
          if (busy_cnt == 32'h0000_0000) begin
            state <= ST_RUN;
            smp_cnt <= 32'h0000_0000;
          end else begin
            busy_cnt <= busy_cnt - ONE;
          end
        end
        default: state <= ST_BOOT;
      endcase
    end
  end

  // ****************************************
  // serial shifter
  // ****************************************
  // the reply for a read is loaded at word end, so it leaves in the next word
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      shreg <= 16'h0000;
      rx <= 16'h0000;
      bitcnt <= 5'h00;
      miso <= 1'b0;
      sync_en <= 1'b0;
      dio_ctrl <= 16'h0000;
      sw_reset <= 1'b0;
      bkup_req <= 1'b0;
      test_req <= 1'b0;
    end else begin
      sw_reset <= 1'b0;
      bkup_req <= 1'b0;
      test_req <= 1'b0;
      if (!cs_act) begin
        bitcnt <= 5'h00; // [R12]
        miso <= shreg[15];
      end else if (sclk_rise) begin
        // mode 3: capture on the rising edge, msb first
        rx <= {rx[14:0], mosi_s[1]}; // [R7] [R13]
        if (bitcnt == 5'h0f) begin
          bitcnt <= 5'h00;
          if (rx[`IMU_WR_BIT - 1]) begin
            // write: each byte address holds one byte; command bits sit in the low byte
            if (rx[13:7] == `IMU_CMD_ADDR) begin
              sw_reset <= rx[6];
              bkup_req <= rx[2];
              test_req <= rx[0];
            end
            if (rx[13:7] == `IMU_DIO_CTRL_ADDR) begin
              dio_ctrl[7:0] <= {rx[6:0], mosi_s[1]};
            end
            if (rx[13:7] == `IMU_DIO_CTRL_ADDR + 7'h01) begin
              dio_ctrl[15:8] <= {rx[6:0], mosi_s[1]};
            end
            if (rx[13:7] == `IMU_MSC_CTRL_ADDR) begin
              sync_en <= rx[`IMU_SYNC_EN_BIT - 1]; // [R11] [R5]
            end
          end else begin
            case (rx[13:7]) // [R14]
              `IMU_DATA_ADDR: shreg <= out_reg;
              `IMU_STATUS_ADDR: shreg <= {14'h0000, sync_en, data_valid};
              `IMU_DIO_CTRL_ADDR: shreg <= dio_ctrl;
              `IMU_MSC_CTRL_ADDR: shreg <= {11'h000, sync_en, 4'h0};
              default: shreg <= 16'h0000;
            endcase
          end
        end else begin
          bitcnt <= bitcnt + 5'h01;
        end
      end else if (sclk_fall) begin
        // shift out on the falling edge
        miso <= shreg[15]; // [R6]
        shreg <= {shreg[14:0], 1'b0};
      end
    end
  end
endmodule

// ---- verif/imu_spi_properties.sv ----
// checker for the sensor serial slave top ports
`timescale 1ns/1ns
module imu_spi_properties #(
  parameter STARTUP_CYC = 200
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // watched select input and outputs
  input wire cs_n,
  input wire miso,
  input wire [3:0] aux_io_out,
  input wire [3:0] aux_io_oe,
  input wire data_valid
);
  // ****************************************
  // helper counters
  // ****************************************
  reg [7:0] hi_cnt;
  reg [31:0] since_rst;
  // pulse length so far, and start-up age saturating at the wait
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      hi_cnt <= 8'h00;
      since_rst <= 32'h0000_0000;
    end else begin
      hi_cnt <= aux_io_out[0] ? hi_cnt + 8'h01 : 8'h00;
      if (since_rst < STARTUP_CYC) since_rst <= since_rst + 32'h0000_0001;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_oe_fixed: assert property (aux_io_oe[0] && !aux_io_oe[3])
    else $error("fixed line directions wrong");
  chk_reset_vals: assert property ($rose(rst_n) |-> aux_io_out == 4'h0 && !data_valid)
    else $error("outputs not cleared by reset");
  chk_drdy_width: assert property ($fell(aux_io_out[0]) |-> hi_cnt == 8'h64)
    else $error("ready pulse width wrong");
  chk_drdy_bound: assert property (hi_cnt <= 8'h64)
    else $error("ready pulse too long");
  chk_startup_quiet: assert property (since_rst < STARTUP_CYC |-> !aux_io_out[0])
    else $error("ready pulse during start-up");
  chk_startup_stale: assert property (since_rst < STARTUP_CYC |-> !data_valid)
    else $error("data valid during start-up");
  chk_drdy_valid: assert property ($rose(aux_io_out[0]) |-> data_valid)
    else $error("ready pulse with invalid data");
  chk_idle_miso: assert property (cs_n [*8] |-> $stable(miso))
    else $error("output moved while deselected");
  cover property ($rose(aux_io_out[0]));
  cover property ($fell(data_valid));
  cover property ($fell(cs_n));
endmodule
bind imu_spi_slave imu_spi_properties #(.STARTUP_CYC(STARTUP_CYC)) i_imu_spi_properties (
  .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .miso(miso),
  .aux_io_out(aux_io_out), .aux_io_oe(aux_io_oe), .data_valid(data_valid));

// ---- verif/imu_host_model.sv ----
// host master model for the sensor serial link
`timescale 1ns/1ns
module imu_host_model #(
  parameter STALL_NS = 9000
) (
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire miso
);
  // clock parks high between frames
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b1;
  end
  // one framed word, msb first; stall leads so words never crowd
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    int i;
    #(STALL_NS);
    cs_n = 1'b0;
    #50;
    for (i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #40 sclk = 1'b1;
      // slave path is slow, so read late in the high phase
      #39 rx[i] = miso;
      #1;
    end
    cs_n = 1'b1;
    mosi = ~mosi;
  endtask
  // clocks with no select, which the slave must not count
  task automatic stray();
    repeat (4) begin
      #40 sclk = 1'b0;
      #40 sclk = 1'b1;
    end
  endtask
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the sensor serial slave
`timescale 1ns/1ns
module tb;
  localparam int ST = 200;
  localparam int RR = 100;
  localparam int FB = 100;
  localparam int FT = 50;
  localparam int SP = 500;
  localparam int SD = 300;
  localparam int DI = 100;
  logic ref_clk, rst_n, sclk, cs_n, mosi, miso, smp_valid, smp_ready, data_valid;
  logic [15:0] smp_data;
  logic [15:0] rx;
  logic [3:0] aux_io_in, aux_io_out, aux_io_oe;
  int err_count, num_checks, n;
  // ****************************************
  // design and host
  // ****************************************
  imu_spi_slave #(.STARTUP_CYC(ST), .RESET_REC_CYC(RR), .FLASH_BKUP_CYC(FB),
    .FLASH_TEST_CYC(FT), .SAMPLE_CYC(SP), .SYNC_TO_DRDY_CYC(SD), .DATA_INVALID_CYC(DI),
    .FIFO_DEPTH(16)) i_imu_spi_slave (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_data(smp_data), .aux_io_in(aux_io_in), .aux_io_out(aux_io_out),
    .aux_io_oe(aux_io_oe), .data_valid(data_valid));
  // stall scaled down with the other times
  imu_host_model #(.STALL_NS(900)) i_imu_host_model (.sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso));
  // free-running reference clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      err_count++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // bounded wait for the next ready rise, n = cycles taken
  task automatic wait_drdy(input int lim);
    logic p;
    p = aux_io_out[0];
    for (n = 1; n <= lim; n++) begin
      @(negedge ref_clk);
      if (aux_io_out[0] === 1'b1 && p !== 1'b1) return;
      p = aux_io_out[0];
    end
    err_count++;
    conclude();
  endtask
  task automatic cmd(input logic [15:0] w);
    i_imu_host_model.xfer(w, rx);
  endtask
  task automatic t_reset();
    check({12'h000, aux_io_out}, 16'h0000);
    check({12'h000, aux_io_oe}, 16'h0001);
    check({15'h0000, data_valid}, 16'h0000);
  endtask
  // fill the sample buffer until it refuses, before sampling drains it
  task automatic t_fill();
    int k;
    k = 0;
    @(posedge ref_clk);
    smp_valid <= 1'b1;
    smp_data <= 16'h5a00;
    while (k < 20) begin
      @(negedge ref_clk);
      if (smp_ready !== 1'b1) break;
      @(posedge ref_clk);
      k++;
      smp_data <= 16'h5a00 + 16'(k);
    end
    @(posedge ref_clk);
    smp_valid <= 1'b0;
    check(16'(k), 16'h0010);
  endtask
  // autonomous rate, then a two-word read ignoring stray clocks
  task automatic t_read();
    wait_drdy(ST + SP + 100);
    wait_drdy(SP + 50);
    check({15'h0000, n >= SP - 1 && n <= SP + 1}, 16'h0001);
    i_imu_host_model.stray();
    cmd({1'b0, 7'h04, 8'h00});
    cmd(16'h0000);
    check(rx, 16'h5a01);
  endtask
  task automatic t_cmds();
    logic [7:0] code [3] = '{8'h08, 8'h02, 8'h80};
    int busy [3] = '{FB, FT, RR};
    int j;
    for (j = 0; j < 3; j++) begin
      cmd({1'b1, 7'h3e, code[j]});
      wait_drdy(busy[j] + SP + 100);
      check({15'h0000, n >= busy[j] + SP - 2 && n <= busy[j] + SP + 4}, 16'h0001);
    end
  endtask
  task automatic t_dio();
    cmd({1'b1, 7'h32, 8'h06});
    cmd({1'b1, 7'h33, 8'h06});
    @(negedge ref_clk);
    check({12'h000, aux_io_oe}, 16'h0007);
    check({14'h0000, aux_io_out[2:1]}, 16'h0003);
    cmd({1'b0, 7'h32, 8'h00});
    cmd(16'h0000);
    check(rx, 16'h0606);
  endtask
  // external sync at the shortest legal period and narrowest pulse
  task automatic t_sync();
    int j, c, hit;
    logic p;
    cmd({1'b1, 7'h34, 8'h10});
    cmd({1'b0, 7'h34, 8'h00});
    cmd({1'b0, 7'h3c, 8'h00});
    check(rx, 16'h0010);
    cmd(16'h0000);
    check(rx, 16'h0003);
    for (j = 0; j < 3; j++) begin
      hit = 0;
      p = 1'b1;
      for (c = 0; c < 910; c++) begin
        @(posedge ref_clk);
        aux_io_in[3] <= (c < 25);
        @(negedge ref_clk);
        if (j > 0 && c == SD - DI + 5) check({15'h0000, data_valid}, 16'h0000);
        if (aux_io_out[0] === 1'b1 && p !== 1'b1 && hit == 0) hit = c;
        p = aux_io_out[0];
      end
      if (j > 0) check({15'h0000, hit >= SD - 3 && hit <= SD + 6}, 16'h0001);
    end
  endtask
  // main sequence, with a second full-length reset after the sync test
  initial begin
    err_count = 0;
    num_checks = 0;
    rst_n = 1'b0;
    smp_valid = 1'b0;
    smp_data = 16'h0000;
    aux_io_in = 4'h0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_fill();
    t_read();
    t_cmds();
    t_dio();
    t_sync();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (1000) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    t_reset();
    conclude();
  end
endmodule
